// ===== hw/hpb_pkg.sv
// Purpose: shared constants and types of the host parallel port
// Assumes: 20 MHz master clock, 5-bit address, byte-wide registers
// Notes: timing figures kept in ns, cycle counts derived here
package hpb_pkg;
  localparam int unsigned HPB_CLK_NS = 50;
  localparam int unsigned HPB_RST_NS = 3000;
  localparam int unsigned HPB_GAP_NS = 2000;
  localparam int unsigned HPB_RST_CYC_I = (HPB_RST_NS + HPB_CLK_NS - 1) /
                                          HPB_CLK_NS;
  localparam logic [7:0] HPB_RST_CYC = 8'(HPB_RST_CYC_I);
  localparam logic [4:0] HPB_AW_ONE = 5'h1;
  localparam logic [5:0] HPB_WIPE_END = 6'h20;
  localparam logic [4:0] HPB_REG_CNT = 5'h16;
  localparam logic [4:0] HPB_OFF_SOFT_RESET = 5'h0a;
  localparam logic [7:0] HPB_REG_RST_VAL = 8'h00;
  localparam logic [12:0] HPB_HW_CTRL_RST = 13'h0000;
  // synchroniser vector layout
  localparam int unsigned HPB_SYN_W = 20;
  localparam int unsigned HPB_P_DATA = 0;
  localparam int unsigned HPB_P_ADDR = 8;
  localparam int unsigned HPB_P_AS = 13;
  localparam int unsigned HPB_P_DIR = 14;
  localparam int unsigned HPB_P_DS = 15;
  localparam int unsigned HPB_P_CS = 16;
  localparam int unsigned HPB_P_MUX = 17;
  localparam int unsigned HPB_P_STYLE = 18;
  localparam int unsigned HPB_P_MODE = 19;

  typedef struct packed {
    logic host_mode;
    logic rw_style;
    logic muxed;
  } hpb_cfg_t;

  localparam hpb_cfg_t HPB_CFG_RST = '{host_mode: 1'b0, rw_style: 1'b0,
                                      muxed: 1'b0};

  typedef struct packed {
    logic cs_n;
    logic ds_n;
    logic dir;
    logic as_n;
  } hpb_strobe_t;

  typedef enum logic [1:0] {
    HPB_IDLE,
    HPB_FETCH,
    HPB_DONE,
    HPB_RESET
  } hpb_state_t;
endpackage

// ===== hw/hpb_regmem.sv
// Purpose: byte-wide register storage for the host port
// Assumes: one write and one read port on the master clock
// Notes: read data comes out of a register, one cycle after the address
`timescale 1ns/1ps
module hpb_regmem
  import hpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem_q [32];
  logic [7:0] rd_data_d;

  always_comb begin
    rd_data_d = mem_q[rd_addr];
  end

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    if (rst) begin
      rd_data <= HPB_REG_RST_VAL;
    end else begin
      rd_data <= rd_data_d;
    end
  end
endmodule // hpb_regmem

// ===== hw/hpb_host_port.sv
// Purpose: 8-bit parallel host port with strap-selected bus styles
// Assumes: all pins asynchronous to clk_sys; strobes active low
// Notes: data_strobe_n doubles as read strobe and dir_wr as write strobe
//   in read/write strobe style; addr_strobe_n doubles as latch enable
// Contract
// - mode strap low gives hardware mode and disables the host bus.
// - hardware mode turns bus pins into static controls and status.
// - mode strap high enables host access over the parallel bus.
// - style pin picks strobe/direction or read/write; mux pin picks bus.
// - separate 5-bit address and 8-bit data, or one shared bus.
// - decode 5-bit address, provide 22 byte-wide registers.
// - wait-state generator drives one acknowledge/ready output.
// - strobe style read: acknowledge low only with valid read data.
// - strobe style write: acknowledge low once write data accepted.
// - read/write style: ready low for the read wait state and muxed reset only; writes keep it high.
// - read/write non-multiplexed reset register write keeps ready high.
// - reset cycle lasts 3 us counted from chip select low.
// - strobe style read: direction high, device drives data bus.
// - strobe non-multiplexed: address latched on data strobe fall; code uses the synchronised address pins unlatched.
// - strobe multiplexed: address latched on address strobe fall.
// - read/write multiplexed: address latched on latch enable fall.
`timescale 1ns/1ps
module hpb_host_port
  import hpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mode_sel,
  input wire logic bus_style_select,
  input wire logic mux_sel,
  input wire logic cs_n,
  input wire logic data_strobe_n,
  input wire logic dir_wr,
  input wire logic addr_strobe_n,
  input wire logic [4:0] host_addr_bus,
  input wire logic [7:0] host_data_in,
  input wire logic [7:0] hw_status,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  output logic ack_rdy,
  output logic [12:0] hw_ctrl,
  output logic reg_wr_stb,
  output logic [4:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic core_rst
);
  logic [HPB_SYN_W-1:0] raw;
  logic [HPB_SYN_W-1:0] s1_q, s2_q, s3_q, stab_q, stab_d;
  hpb_strobe_t stb;
  hpb_cfg_t cfg_q, cfg_d;
  hpb_state_t st_q, st_d;
  logic as_prev_q, as_prev_d;
  logic [4:0] addr_q, addr_d;
  logic [7:0] cnt_q, cnt_d;
  logic [5:0] wipe_q, wipe_d;
  logic [7:0] dout_q, dout_d;
  logic oe_q, oe_d, ack_q, ack_d, core_rst_q, core_rst_d;
  logic [12:0] hw_q, hw_d;
  logic wstb_q, wstb_d;
  logic [4:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic mem_we;
  logic [4:0] mem_waddr, mem_raddr;
  logic [7:0] mem_wdata, mem_rdata;
  logic access, is_read, as_fall, addr_ok;
  logic [4:0] cyc_addr, bus_addr;
  logic [7:0] bus_data;

  assign raw = {mode_sel, bus_style_select, mux_sel, cs_n, data_strobe_n,
                dir_wr, addr_strobe_n, host_addr_bus, host_data_in};

  // three-stage synchroniser; a change counts when stages two and three agree
  always_comb begin
    for (int i = 0; i < HPB_SYN_W; i++) begin
      stab_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stab_q[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      stab_q <= '1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stab_q <= stab_d;
    end
  end

  assign stb = '{cs_n: stab_q[HPB_P_CS], ds_n: stab_q[HPB_P_DS],
                dir: stab_q[HPB_P_DIR], as_n: stab_q[HPB_P_AS]};
  assign bus_addr = stab_q[HPB_P_ADDR +: 5];
  assign bus_data = stab_q[HPB_P_DATA +: 8];
  assign as_fall = as_prev_q & ~stb.as_n;

  always_comb begin
    if (cfg_q.rw_style) begin
      // read strobe on data_strobe_n, write strobe on dir_wr
      access = ~stb.cs_n & (~stb.ds_n | ~stb.dir);
      is_read = ~stb.ds_n;
    end else begin
      access = ~stb.cs_n & ~stb.ds_n;
      is_read = stb.dir;
    end
    // separate address pins or the address latched off the shared bus
    cyc_addr = cfg_q.muxed ? addr_q : bus_addr;
    addr_ok = cyc_addr < HPB_REG_CNT;
  end

  always_comb begin
    st_d = st_q;
    cfg_d = cfg_q;
    as_prev_d = stb.as_n;
    addr_d = addr_q;
    cnt_d = stb.cs_n ? 8'h00 : cnt_q + 8'h01;
    wipe_d = wipe_q;
    dout_d = dout_q;
    oe_d = oe_q;
    ack_d = ack_q;
    core_rst_d = 1'b0;
    hw_d = hw_q;
    wstb_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    mem_we = 1'b0;
    mem_waddr = cyc_addr;
    mem_wdata = bus_data;
    mem_raddr = cyc_addr;
    if (cfg_q.muxed && as_fall) begin
      addr_d = bus_data[4:0];
    end
    case (st_q)
      HPB_IDLE: begin
        // straps only take effect between bus cycles
        cfg_d = '{host_mode: stab_q[HPB_P_MODE],
                  rw_style: stab_q[HPB_P_STYLE],
                  muxed: stab_q[HPB_P_MUX]};
        ack_d = 1'b1;
        if (!cfg_q.host_mode) begin
          // config leaves reset as hardware mode; drive pins only once
          // the synchronised strap agrees, so host mode sees no glitch
          if (!stab_q[HPB_P_MODE]) begin
            hw_d = {bus_addr, bus_data};
            dout_d = hw_status;
          end
          oe_d = ~stab_q[HPB_P_MODE];
        end else begin
          oe_d = 1'b0;
          if (access && is_read) begin
            st_d = HPB_FETCH;
            ack_d = ~cfg_q.rw_style;
          end else if (access && cyc_addr == HPB_OFF_SOFT_RESET) begin
            st_d = HPB_RESET;
            wipe_d = 6'h00;
            ack_d = cfg_q.rw_style & ~cfg_q.muxed;
          end else if (access) begin
            mem_we = addr_ok;
            wstb_d = addr_ok;
            waddr_d = cyc_addr;
            wdata_d = bus_data;
            st_d = HPB_DONE;
            ack_d = cfg_q.rw_style;
          end
        end
      end
      HPB_FETCH: begin
        dout_d = addr_ok ? mem_rdata : 8'h00;
        oe_d = 1'b1;
        ack_d = cfg_q.rw_style;
        st_d = HPB_DONE;
      end
      HPB_DONE: begin
        if (!access) begin
          oe_d = 1'b0;
          ack_d = 1'b1;
          st_d = HPB_IDLE;
        end
      end
      HPB_RESET: begin
        core_rst_d = 1'b1;
        if (wipe_q != HPB_WIPE_END) begin
          mem_we = 1'b1;
          mem_waddr = wipe_q[4:0];
          mem_wdata = HPB_REG_RST_VAL;
          wipe_d = wipe_q + 6'h01;
        end
        cnt_d = cnt_q + 8'h01;
        if (cnt_q >= HPB_RST_CYC - 8'h01 && wipe_q == HPB_WIPE_END) begin
          core_rst_d = 1'b0;
          ack_d = cfg_q.rw_style;
          st_d = access ? HPB_DONE : HPB_IDLE;
        end
      end
      default: begin
        st_d = HPB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= HPB_IDLE;
      cfg_q <= HPB_CFG_RST;
      as_prev_q <= 1'b1;
      addr_q <= 5'h00;
      cnt_q <= 8'h00;
      wipe_q <= 6'h00;
      dout_q <= 8'h00;
      oe_q <= 1'b0;
      ack_q <= 1'b1;
      core_rst_q <= 1'b0;
      hw_q <= HPB_HW_CTRL_RST;
      wstb_q <= 1'b0;
      waddr_q <= 5'h00;
      wdata_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cfg_q <= cfg_d;
      as_prev_q <= as_prev_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      wipe_q <= wipe_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      ack_q <= ack_d;
      core_rst_q <= core_rst_d;
      hw_q <= hw_d;
      wstb_q <= wstb_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  hpb_regmem u_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  assign host_data_out = dout_q;
  assign host_data_oe = oe_q;
  assign ack_rdy = ack_q;
  assign hw_ctrl = hw_q;
  assign reg_wr_stb = wstb_q;
  assign reg_wr_addr = waddr_q;
  assign reg_wr_data = wdata_q;
  assign core_rst = core_rst_q;
endmodule // hpb_host_port

// ===== verification/hpb_monitor.sv
// Purpose: port checks for hpb_host_port
// Assumes: straps move only while the bus is idle
// Notes: bound from tb
`timescale 1ns/1ps
module hpb_monitor
  import hpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mode_sel,
  input wire logic bus_style_select,
  input wire logic mux_sel,
  input wire logic cs_n,
  input wire logic dir_wr,
  input wire logic host_data_oe,
  input wire logic ack_rdy,
  input wire logic reg_wr_stb,
  input wire logic [4:0] reg_wr_addr,
  input wire logic core_rst
);
  logic [7:0] age_q, age_d, len_q, len_d;
  // cycles chip select has been low, and length of the soft reset
  always_comb begin
    age_d = cs_n ? 8'h00 : age_q + {7'h00, age_q != 8'hff};
    len_d = core_rst ? len_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk_sys) begin
    age_q <= rst ? 8'h00 : age_d;
    len_q <= rst ? 8'h00 : len_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_RST_IDLE:
    assert property (disable iff (1'b0) rst |=> ack_rdy && !core_rst
      && !host_data_oe) else $error("port not idle after reset");
  AST_HW_QUIET:
    assert property ((!mode_sel) [*8] |-> !reg_wr_stb && !core_rst)
      else $error("access in hw mode");
  AST_WR_CS:
    assert property (reg_wr_stb |-> age_q > 8'h02)
      else $error("write without cs");
  AST_WR_MAP:
    assert property (reg_wr_stb |-> reg_wr_addr < HPB_REG_CNT)
      else $error("write to unmapped place");
  AST_STB_ONE:
    assert property (reg_wr_stb |=> !reg_wr_stb)
      else $error("long write pulse");
  AST_RD_ACK:
    assert property ($fell(ack_rdy) && mode_sel && !bus_style_select
      && dir_wr |-> host_data_oe) else $error("ack before data");
  AST_OE_CS:
    assert property ($rose(host_data_oe) && mode_sel |-> age_q > 8'h03)
      else $error("drive without cs");
  AST_RW_WR_HI:
    assert property (mode_sel && bus_style_select && !mux_sel && !cs_n
      && !dir_wr |-> ack_rdy) else $error("ready low on write");
  AST_RST_ACK:
    assert property ($rose(core_rst) && !bus_style_select |-> ##[0:2]
      !ack_rdy) else $error("no ack in reset");
  AST_RST_LEN:
    assert property ($fell(core_rst) |-> len_q > HPB_RST_CYC - 8'h0b
      && len_q <= HPB_RST_CYC) else $error("bad reset length");
  AST_RW_RD_WAIT:
    assert property ($rose(host_data_oe) && mode_sel && bus_style_select
      |-> ack_rdy && !$past(ack_rdy)) else $error("no wait state on read");
endmodule // hpb_monitor

// ===== verification/hpb_host_model.sv
// Purpose: host processor on the parallel port
// Assumes: one transfer at a time
// Notes: lines the host does not drive carry inverted data
`timescale 1ns/1ps
module hpb_host_model
  import hpb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic bus_style_select,
  input wire logic mux_sel,
  input wire logic ack_rdy,
  input wire logic host_data_oe,
  input wire logic [7:0] host_data_out,
  output logic cs_n,
  output logic data_strobe_n,
  output logic dir_wr,
  output logic addr_strobe_n,
  output logic [4:0] host_addr_bus,
  output logic [7:0] host_data_in
);
  initial begin
    {cs_n, data_strobe_n, dir_wr, addr_strobe_n} = 4'hf;
    {host_addr_bus, host_data_in} = 13'h0000;
  end
  task automatic hold(input logic [12:0] v);
    @(posedge clk_sys);
    {host_addr_bus, host_data_in} <= v;
  endtask
  task automatic xfer(input logic rd, input logic [4:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic late);
    int n;
    n = 0;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    host_addr_bus <= mux_sel ? ~a : a;
    host_data_in <= mux_sel ? {3'h0, a} : d;
    addr_strobe_n <= !mux_sel;
    if (mux_sel) begin
      repeat (6) @(posedge clk_sys);
      host_data_in <= d;
    end
    data_strobe_n <= bus_style_select && !rd;
    dir_wr <= rd;
    while (n < 40 && (bus_style_select ? (rd ? !host_data_oe : n < 12)
      : ack_rdy)) begin
      @(posedge clk_sys);
      n++;
    end
    q = host_data_out;
    late = (n >= 40);
    {cs_n, data_strobe_n, dir_wr, addr_strobe_n} <= 4'hf;
    host_data_in <= ~d;
    repeat (10) @(posedge clk_sys);
  endtask
endmodule // hpb_host_model

// ===== verification/tb.sv
// Purpose: self-checking bench of hpb_host_port
// Assumes: host model drives the bus pins
// Notes: straps change only between transfers
`timescale 1ns/1ps
module tb;
  import hpb_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic mode_sel = 1'b1;
  logic bus_style_select = 1'b0;
  logic mux_sel = 1'b0;
  logic [7:0] hw_status = 8'h3c;
  logic cs_n, data_strobe_n, dir_wr, addr_strobe_n, host_data_oe;
  logic ack_rdy, reg_wr_stb, core_rst;
  logic [4:0] host_addr_bus, reg_wr_addr;
  logic [7:0] host_data_in, host_data_out, reg_wr_data;
  logic [12:0] hw_ctrl, last_wr;
  int err_total = 0;
  int check_count = 0;
  int n_wr = 0;
  int n_rc = 0;
  int cyc = 0;
  always #25 clk_sys = ~clk_sys;
  hpb_host_port i_dut (.clk_sys, .rst, .mode_sel, .bus_style_select,
    .mux_sel, .cs_n, .data_strobe_n, .dir_wr, .addr_strobe_n,
    .host_addr_bus, .host_data_in, .hw_status, .host_data_out,
    .host_data_oe, .ack_rdy, .hw_ctrl, .reg_wr_stb, .reg_wr_addr,
    .reg_wr_data, .core_rst);
  hpb_host_model i_host (.clk_sys, .bus_style_select, .mux_sel, .ack_rdy,
    .host_data_oe, .host_data_out, .cs_n, .data_strobe_n, .dir_wr,
    .addr_strobe_n, .host_addr_bus, .host_data_in);
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic rd, input logic [4:0] a,
    input logic [7:0] e);
    logic [7:0] q;
    logic late;
    i_host.xfer(rd, a, rd ? ~e : e, q, late);
    chk({12'h000, late}, 13'h0000);
    if (rd) chk({5'h00, q}, {5'h00, e});
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    n_rc <= n_rc + int'(core_rst);
    if (reg_wr_stb) begin
      n_wr <= n_wr + 1;
      last_wr <= {reg_wr_addr, reg_wr_data};
    end
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    int w;
    int r;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      {bus_style_select, mux_sel} <= 2'(m);
      repeat (8) @(posedge clk_sys);
      acc(1'b0, 5'h15, 8'ha5 ^ 8'(m));
      chk(last_wr, {5'h15, 8'ha5 ^ 8'(m)});
      acc(1'b1, 5'h15, 8'ha5 ^ 8'(m));
      w = n_wr;
      acc(1'b0, 5'h17, 8'h11);
      chk(13'(n_wr - w), 13'h0000);
      acc(1'b1, 5'h17, 8'h00);
      r = n_rc;
      acc(1'b0, HPB_OFF_SOFT_RESET, 8'h01);
      repeat (80) @(posedge clk_sys);
      chk(13'(n_rc > r), 13'h0001);
      acc(1'b1, 5'h15, 8'h00);
    end
    @(posedge clk_sys);
    mode_sel <= 1'b0;
    repeat (8) @(posedge clk_sys);
    w = n_wr;
    acc(1'b0, 5'h01, 8'h22);
    chk(13'(n_wr - w), 13'h0000);
    i_host.hold(13'h1abc);
    repeat (10) @(posedge clk_sys);
    chk(hw_ctrl, 13'h1abc);
    chk({4'h0, host_data_oe, host_data_out}, {5'h01, hw_status});
    stop_test();
  end
endmodule // tb
bind hpb_host_port hpb_monitor i_mon (.clk_sys, .rst, .mode_sel,
  .bus_style_select, .mux_sel, .cs_n, .dir_wr, .host_data_oe, .ack_rdy,
  .reg_wr_stb, .reg_wr_addr, .core_rst);
